// file: rtl/exec_pkg.sv
// shared constants and carriers for the branch, skip and fractional multiply slice
// assumes a 16-bit instruction word and a 22-bit word-addressed program counter
package exec_pkg;

   // ----------------------------------------------------------------
   // widths and reset values
   // ----------------------------------------------------------------
   localparam int PC_W = 22;
   localparam logic [21:0] PC_RESET = 22'h000000;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] FLAGS_RESET = 8'h00;

   // ----------------------------------------------------------------
   // cycle counts
   // ----------------------------------------------------------------
   localparam logic [2:0] CYC_ONE = 3'h1;
   localparam logic [2:0] CYC_MULT = 3'h2;
   localparam logic [2:0] CYC_INDIRECT = 3'h2;
   localparam logic [2:0] CYC_BRANCH_TAKEN = 3'h2;
   localparam logic [2:0] CYC_SKIP_SHORT = 3'h2;
   localparam logic [2:0] CYC_SKIP_LONG = 3'h3;
   localparam logic [2:0] CYC_ABSOLUTE = 3'h3;
   localparam logic [2:0] CYC_EXIT = 3'h4;

   // ----------------------------------------------------------------
   // opcode masks and values
   // ----------------------------------------------------------------
   localparam logic [15:0] M_FMUL = 16'hFF80;
   localparam logic [15:0] V_FMUL = 16'h0380;
   localparam logic [15:0] M_EXACT = 16'hFFFF;
   localparam logic [15:0] V_IND_JUMP = 16'h9409;
   localparam logic [15:0] V_EXT_IND_JUMP = 16'h9419;
   localparam logic [15:0] V_IND_CALL = 16'h9509;
   localparam logic [15:0] V_EXT_IND_CALL = 16'h9519;
   localparam logic [15:0] V_SUB_EXIT = 16'h9508;
   localparam logic [15:0] V_INT_EXIT = 16'h9518;
   localparam logic [15:0] M_ABS = 16'hFE0E;
   localparam logic [15:0] V_ABS_JUMP = 16'h940C;
   localparam logic [15:0] V_ABS_CALL = 16'h940E;
   localparam logic [15:0] M_ABS_ANY = 16'hFE0C;
   localparam logic [15:0] M_DIRECT = 16'hFC0F;
   localparam logic [15:0] V_DIRECT = 16'h9000;
   localparam logic [15:0] M_TWO_REG = 16'hFC00;
   localparam logic [15:0] V_COMPARE_SKIP_EQUAL = 16'h1000;
   localparam logic [15:0] V_CP = 16'h1400;
   localparam logic [15:0] V_CPC = 16'h0400;
   localparam logic [15:0] V_MOV = 16'h2C00;
   localparam logic [15:0] M_IMM = 16'hF000;
   localparam logic [15:0] V_CPI = 16'h3000;
   localparam logic [15:0] V_LDI = 16'hE000;
   localparam logic [15:0] M_PAIR = 16'hFF00;
   localparam logic [15:0] V_REGISTER_PAIR_COPY = 16'h0100;
   localparam logic [15:0] M_BITSKIP = 16'hFC08;
   localparam logic [15:0] V_SKIP_CLR = 16'hFC00;
   localparam logic [15:0] V_SKIP_SET = 16'hFE00;
   localparam logic [15:0] M_BRANCH = 16'hF800;
   localparam logic [15:0] V_BR_ONE = 16'hF000;
   localparam logic [15:0] V_BR_ZERO = 16'hF400;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic i;
      logic t;
      logic h;
      logic s;
      logic v;
      logic n;
      logic z;
      logic c;
   } status_s;

   typedef struct packed {
      logic strobe;
      logic [21:0] addr;
   } stack_s;

endpackage : exec_pkg

// file: rtl/frac_mult.sv
// fractional multiplier: signed by signed or signed by unsigned, product shifted left once
// assumes operands are stable during the cycle they are used
`timescale 1ns/100ps
module frac_mult (
   // operands
   input wire logic [7:0] mulA,
   input wire logic [7:0] mulB,
   input wire logic bUnsigned,
   // result
   output logic [15:0] product,
   output logic carry
);
   logic signed [8:0] extA;
   logic signed [8:0] extB;
   logic signed [17:0] raw;

   // sign extend, multiply, shift left by one
   always_comb begin
      extA = $signed({mulA[7], mulA});
      extB = bUnsigned ? $signed({1'b0, mulB}) : $signed({mulB[7], mulB});
      raw = extA * extB;
      carry = raw[15]; // bit lost by the shift
      product = {raw[14:0], 1'b0};
   end
endmodule : frac_mult

// file: rtl/branch_skip_fracmul_exec.sv
// execution slice: fractional multiplies, jumps, calls, exits, skips, branches, compares, moves
// assumes program memory presents the word at fetchPc and the word after it together
`timescale 1ns/100ps
module branch_skip_fracmul_exec (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // instruction stream
   input wire logic instrValid,
   input wire logic [15:0] instrWord,
   input wire logic [15:0] followWord,
   output logic instrReady,
   output logic [21:0] fetchPc,
   output logic retire,
   output logic unknownOp,
   // extended addressing
   input wire logic extAddrSupported,
   input wire logic [5:0] extIndHigh,
   // stack
   output exec_pkg::stack_s pushReq,
   input wire logic [21:0] popAddr,
   // observation
   output exec_pkg::status_s statusFlags,
   input wire logic [4:0] peekAddr,
   output logic [7:0] peekData
);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   function automatic logic isOp(input logic [15:0] w, input logic [15:0] m,
                                 input logic [15:0] v);
      isOp = (w & m) == v;
   endfunction : isOp

   // subtract without storing, returns new flags
   function automatic exec_pkg::status_s cmpFlags(input exec_pkg::status_s old,
         input logic [7:0] a, input logic [7:0] b, input logic cin, input logic chainZ);
      logic [7:0] r;
      exec_pkg::status_s f;
      r = a - b - {7'h00, cin};
      f = old;
      f.h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      f.v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
      f.n = r[7];
      f.s = f.n ^ f.v;
      f.z = (r == 8'h00) & (~chainZ | old.z);
      f.c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
      cmpFlags = f;
   endfunction : cmpFlags

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic {S_READY, S_BUSY} phase_e;
   phase_e phaseFf;
   logic [2:0] waitFf;
   logic [21:0] pcFf;
   exec_pkg::status_s flagsFf;
   logic [7:0] regFile [32];
   logic retireFf;
   logic unknownFf;
   exec_pkg::stack_s pushFf;
   logic [7:0] peekFf;

   // next values from decode
   logic [21:0] nxt_pc;
   exec_pkg::status_s nxt_flags;
   logic [2:0] nxt_cycles;
   logic nxt_push;
   logic [21:0] nxt_pushAddr;
   logic nxt_unknown;
   logic wrOne;
   logic wrPair;
   logic [4:0] wrAddr;
   logic [7:0] wrByte;
   logic [15:0] wrWord;

   logic accept;
   logic [15:0] zPtr;
   logic [21:0] pcPlusOne;
   logic [21:0] branchTarget;
   logic nextIsLong;
   logic [21:0] skipTarget;
   logic [2:0] skipCycles;
   logic [7:0] opD;
   logic [7:0] opR;
   logic [7:0] immVal;
   logic [7:0] opImmD;
   logic [7:0] bitReg;
   logic [7:0] flagVec;
   logic [15:0] fracProduct;
   logic fracCarry;

   // ----------------------------------------------------------------
   // operand fetch
   // ----------------------------------------------------------------
   assign accept = instrValid & instrReady;
   assign zPtr = {regFile[31], regFile[30]};
   assign pcPlusOne = pcFf + 22'h000001;
   assign branchTarget = pcPlusOne + {{15{instrWord[9]}}, instrWord[9:3]};
   assign nextIsLong = isOp(followWord, exec_pkg::M_ABS_ANY, exec_pkg::V_ABS_JUMP)
                     | isOp(followWord, exec_pkg::M_DIRECT, exec_pkg::V_DIRECT)
                     | isOp(followWord, exec_pkg::M_DIRECT, exec_pkg::V_DIRECT | 16'h0200);
   // skip over one or two words
   assign skipTarget = nextIsLong ? pcFf + 22'h000003 : pcFf + 22'h000002;
   assign skipCycles = nextIsLong ? exec_pkg::CYC_SKIP_LONG : exec_pkg::CYC_SKIP_SHORT;
   assign opD = regFile[instrWord[8:4]];
   assign opR = regFile[{instrWord[9], instrWord[3:0]}];
   assign immVal = {instrWord[11:8], instrWord[3:0]};
   assign opImmD = regFile[{1'b1, instrWord[7:4]}];
   assign bitReg = regFile[instrWord[8:4]];
   assign flagVec = flagsFf;

   // fractional multiplier on registers 16 to 23
   frac_mult uMult (
      .mulA(regFile[{2'b10, instrWord[6:4]}]),
      .mulB(regFile[{2'b10, instrWord[2:0]}]),
      .bUnsigned(instrWord[3]),
      .product(fracProduct),
      .carry(fracCarry)
   );

   // ----------------------------------------------------------------
   // decode and execute
   // ----------------------------------------------------------------
   // one instruction per accept, effects and cycle count
   always_comb begin
      nxt_pc = pcPlusOne;
      nxt_flags = flagsFf;
      nxt_cycles = exec_pkg::CYC_ONE;
      nxt_push = 1'b0;
      nxt_pushAddr = pcPlusOne;
      nxt_unknown = 1'b0;
      wrOne = 1'b0;
      wrPair = 1'b0;
      wrAddr = instrWord[8:4];
      wrByte = opR;
      wrWord = fracProduct;
      if (isOp(instrWord, exec_pkg::M_FMUL, exec_pkg::V_FMUL)) begin
         wrPair = 1'b1;
         wrAddr = 5'h00;
         nxt_flags.z = (fracProduct == 16'h0000);
         nxt_flags.c = fracCarry;
         nxt_cycles = exec_pkg::CYC_MULT;
      end else if (isOp(instrWord, exec_pkg::M_EXACT, exec_pkg::V_IND_JUMP)) begin
         nxt_pc = {6'h00, zPtr};
         nxt_cycles = exec_pkg::CYC_INDIRECT;
      end else if (isOp(instrWord, exec_pkg::M_EXACT, exec_pkg::V_EXT_IND_JUMP)
                   && extAddrSupported) begin
         nxt_pc = {extIndHigh, zPtr};
         nxt_cycles = exec_pkg::CYC_INDIRECT;
      end else if (isOp(instrWord, exec_pkg::M_EXACT, exec_pkg::V_IND_CALL)) begin
         nxt_pc = {6'h00, zPtr};
         nxt_push = 1'b1;
         nxt_cycles = exec_pkg::CYC_INDIRECT;
      end else if (isOp(instrWord, exec_pkg::M_EXACT, exec_pkg::V_EXT_IND_CALL)
                   && extAddrSupported) begin
         nxt_pc = {extIndHigh, zPtr};
         nxt_push = 1'b1;
         nxt_cycles = exec_pkg::CYC_INDIRECT;
      end else if (isOp(instrWord, exec_pkg::M_EXACT, exec_pkg::V_SUB_EXIT)) begin
         nxt_pc = popAddr;
         nxt_cycles = exec_pkg::CYC_EXIT;
      end else if (isOp(instrWord, exec_pkg::M_EXACT, exec_pkg::V_INT_EXIT)) begin
         nxt_pc = popAddr;
         nxt_flags.i = 1'b1;
         nxt_cycles = exec_pkg::CYC_EXIT;
      end else if (isOp(instrWord, exec_pkg::M_ABS, exec_pkg::V_ABS_JUMP)
                   || isOp(instrWord, exec_pkg::M_ABS, exec_pkg::V_ABS_CALL)) begin
         nxt_pc = {instrWord[8:4], instrWord[0], followWord};
         nxt_push = instrWord[1];
         nxt_pushAddr = pcFf + 22'h000002;
         nxt_cycles = exec_pkg::CYC_ABSOLUTE;
      end else if (isOp(instrWord, exec_pkg::M_TWO_REG, exec_pkg::V_COMPARE_SKIP_EQUAL)) begin
         if (opD == opR) begin
            nxt_pc = skipTarget;
            nxt_cycles = skipCycles;
         end
      end else if (isOp(instrWord, exec_pkg::M_TWO_REG, exec_pkg::V_CP)) begin
         nxt_flags = cmpFlags(flagsFf, opD, opR, 1'b0, 1'b0);
      end else if (isOp(instrWord, exec_pkg::M_TWO_REG, exec_pkg::V_CPC)) begin
         nxt_flags = cmpFlags(flagsFf, opD, opR, flagsFf.c, 1'b1);
      end else if (isOp(instrWord, exec_pkg::M_IMM, exec_pkg::V_CPI)) begin
         nxt_flags = cmpFlags(flagsFf, opImmD, immVal, 1'b0, 1'b0);
      end else if (isOp(instrWord, exec_pkg::M_BITSKIP, exec_pkg::V_SKIP_CLR)
                   || isOp(instrWord, exec_pkg::M_BITSKIP, exec_pkg::V_SKIP_SET)) begin
         if (bitReg[instrWord[2:0]] == instrWord[9]) begin
            nxt_pc = skipTarget;
            nxt_cycles = skipCycles;
         end
      end else if (isOp(instrWord, exec_pkg::M_BRANCH, exec_pkg::V_BR_ONE)
                   || isOp(instrWord, exec_pkg::M_BRANCH, exec_pkg::V_BR_ZERO)) begin
         // flag index 4 is N xor V, 5 half carry, 3 overflow, 0 carry, 6 T
         if (flagVec[instrWord[2:0]] == ~instrWord[10]) begin
            nxt_pc = branchTarget;
            nxt_cycles = exec_pkg::CYC_BRANCH_TAKEN;
         end
      end else if (isOp(instrWord, exec_pkg::M_TWO_REG, exec_pkg::V_MOV)) begin
         wrOne = 1'b1;
      end else if (isOp(instrWord, exec_pkg::M_PAIR, exec_pkg::V_REGISTER_PAIR_COPY)) begin
         wrPair = 1'b1;
         wrAddr = {instrWord[7:4], 1'b0};
         wrWord = {regFile[{instrWord[3:0], 1'b1}], regFile[{instrWord[3:0], 1'b0}]};
      end else if (isOp(instrWord, exec_pkg::M_IMM, exec_pkg::V_LDI)) begin
         wrOne = 1'b1;
         wrAddr = {1'b1, instrWord[7:4]};
         wrByte = immVal;
      end else begin
         nxt_unknown = 1'b1; // not this slice: one-cycle no-op
      end
   end

   // ----------------------------------------------------------------
   // sequencing
   // ----------------------------------------------------------------
   assign instrReady = (phaseFf == S_READY);

   // hold off further instructions for the extra cycles
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         phaseFf <= S_READY;
         waitFf <= 3'h0;
      end else begin
         unique case (phaseFf)
            S_READY: begin
               if (accept && nxt_cycles != exec_pkg::CYC_ONE) begin
                  phaseFf <= S_BUSY;
                  waitFf <= nxt_cycles - exec_pkg::CYC_ONE;
               end
            end
            S_BUSY: begin
               waitFf <= waitFf - 3'h1;
               if (waitFf == 3'h1) begin
                  phaseFf <= S_READY;
               end
            end
         endcase
      end
   end

   // completion and side-effect pulses
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         retireFf <= 1'b0;
         unknownFf <= 1'b0;
         pushFf <= '0;
      end else begin
         retireFf <= (accept && nxt_cycles == exec_pkg::CYC_ONE)
                   || (phaseFf == S_BUSY && waitFf == 3'h1);
         unknownFf <= accept & nxt_unknown;
         pushFf.strobe <= accept & nxt_push;
         pushFf.addr <= accept ? nxt_pushAddr : pushFf.addr;
      end
   end

   // ----------------------------------------------------------------
   // architectural state
   // ----------------------------------------------------------------
   // program counter and status flags
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pcFf <= exec_pkg::PC_RESET;
         flagsFf <= exec_pkg::FLAGS_RESET;
      end else if (accept) begin
         pcFf <= nxt_pc;
         flagsFf <= nxt_flags;
      end
   end

   // register file writes and observation port
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < 32; i++) begin
            regFile[i] <= exec_pkg::REG_RESET;
         end
         peekFf <= exec_pkg::REG_RESET;
      end else begin
         if (accept && wrOne) begin
            regFile[wrAddr] <= wrByte;
         end
         if (accept && wrPair) begin
            regFile[wrAddr] <= wrWord[7:0];
            regFile[wrAddr + 5'h01] <= wrWord[15:8];
         end
         peekFf <= regFile[peekAddr];
      end
   end

   assign fetchPc = pcFf;
   assign retire = retireFf;
   assign unknownOp = unknownFf;
   assign pushReq = pushFf;
   assign statusFlags = flagsFf;
   assign peekData = peekFf;

endmodule : branch_skip_fracmul_exec

// file: dv/prog_mem_model.sv
// program memory model: serves the word at the counter and the word after it
// assumes the bench loads a word pair ahead of each fetch
`timescale 1ns/100ps
module prog_mem_model (
   // clock
   input wire logic clk,
   // loading from the bench
   input wire logic ldEn,
   input wire logic [7:0] ldAddr,
   input wire logic [31:0] ldData,
   // fetch side
   input wire logic [21:0] fetchPc,
   output logic [15:0] instrWord,
   output logic [15:0] followWord
);
   // ----------------------------------------
   // storage
   // ----------------------------------------
   logic [15:0] mem [256];
   // instruction and following word written together
   always @(posedge clk) begin
      if (ldEn) begin
         mem[ldAddr] <= ldData[31:16];
         mem[ldAddr + 8'h01] <= ldData[15:0];
      end
   end
   // both words presented at once, low counter bits only
   assign instrWord = mem[fetchPc[7:0]];
   assign followWord = mem[fetchPc[7:0] + 8'h01];
endmodule : prog_mem_model

// file: dv/branch_skip_fracmul_exec_monitor.sv
// checker: timing, counter and flag relations at the slice ports
// assumes accept on instrValid with instrReady, synchronous active-high reset
`timescale 1ns/100ps
module branch_skip_fracmul_exec_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // instruction stream
   input wire logic instrValid,
   input wire logic [15:0] instrWord,
   input wire logic [15:0] followWord,
   input wire logic instrReady,
   input wire logic [21:0] fetchPc,
   input wire logic retire,
   input wire logic unknownOp,
   // extended addressing and stack
   input wire logic extAddrSupported,
   input wire logic [5:0] extIndHigh,
   input wire exec_pkg::stack_s pushReq,
   input wire logic [21:0] popAddr,
   // flags
   input wire exec_pkg::status_s statusFlags
);
   // ----------------------------------------
   // helpers and assertions
   // ----------------------------------------
   logic acc;
   logic taken;
   logic [21:0] dest;
   // accept strobe, branch condition and target
   assign acc = instrValid && instrReady;
   assign taken = statusFlags[instrWord[2:0]] ^ instrWord[10];
   assign dest = fetchPc + {{15{instrWord[9]}}, instrWord[9:3]} + 22'h000001;
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   chk_fmul_cycles: assert property (
      acc && (instrWord & exec_pkg::M_FMUL) == exec_pkg::V_FMUL |=> (!instrReady
      && statusFlags[7:2] == $past(statusFlags[7:2])) ##1 (instrReady && retire))
      else $error("fractional multiply timing or flags wrong");
   chk_ijump_flags: assert property (
      acc && instrWord == exec_pkg::V_IND_JUMP |=> (statusFlags == $past(statusFlags)
      && !pushReq.strobe) ##1 retire) else $error("indirect jump wrong");
   chk_ext_jump: assert property (
      acc && instrWord == exec_pkg::V_EXT_IND_JUMP && extAddrSupported
      |=> fetchPc[21:16] == $past(extIndHigh) ##1 retire) else $error("extended jump wrong");
   chk_ext_refused: assert property (
      acc && instrWord[15:4] == 12'h941 && !extAddrSupported |=> unknownOp && retire
      && fetchPc == $past(fetchPc) + 22'h000001) else $error("unsupported extended op wrong");
   chk_indirect_subroutine_invoke_push: assert property (
      acc && instrWord == exec_pkg::V_IND_CALL |=> (pushReq.strobe && pushReq.addr ==
      $past(fetchPc) + 22'h000001 && statusFlags == $past(statusFlags)) ##1 retire)
      else $error("indirect call wrong");
   chk_ext_call: assert property (
      acc && instrWord == exec_pkg::V_EXT_IND_CALL && extAddrSupported |=> (pushReq.strobe
      && fetchPc[21:16] == $past(extIndHigh)) ##1 retire) else $error("extended call wrong");
   chk_branch_taken: assert property (
      acc && (instrWord & exec_pkg::M_BRANCH) == exec_pkg::V_BR_ONE && taken
      |=> (fetchPc == $past(dest) && !instrReady) ##1 retire) else $error("taken branch wrong");
   chk_branch_fall: assert property (
      acc && (instrWord & exec_pkg::M_BRANCH) == exec_pkg::V_BR_ONE && !taken
      |=> retire && fetchPc == $past(fetchPc) + 22'h000001) else $error("branch fall wrong");
   chk_exit_wait: assert property (
      acc && (instrWord & 16'hFFEF) == exec_pkg::V_SUB_EXIT |=> (fetchPc == $past(popAddr)
      && !instrReady) ##1 (!instrReady)[*2] ##1 retire) else $error("exit timing wrong");
   chk_interrupt_exit_sets: assert property (
      acc && instrWord == exec_pkg::V_INT_EXIT |=> statusFlags.i) else $error("exit flag wrong");
   chk_abs_target: assert property (
      acc && (instrWord & exec_pkg::M_ABS) == exec_pkg::V_ABS_JUMP |=> (fetchPc ==
      {$past(instrWord[8:4]), $past(instrWord[0]), $past(followWord)} && !instrReady)
      ##2 retire) else $error("absolute jump wrong");
   chk_copy_flags: assert property (
      acc && ((instrWord & exec_pkg::M_IMM) == exec_pkg::V_LDI || (instrWord &
      exec_pkg::M_PAIR) == exec_pkg::V_REGISTER_PAIR_COPY) |=> retire && statusFlags == $past(statusFlags))
      else $error("copy touched flags");
endmodule : branch_skip_fracmul_exec_monitor

bind branch_skip_fracmul_exec branch_skip_fracmul_exec_monitor monitorInst (
   .clk(clk), .sys_rst(sys_rst), .instrValid(instrValid), .instrWord(instrWord),
   .followWord(followWord), .instrReady(instrReady), .fetchPc(fetchPc), .retire(retire),
   .unknownOp(unknownOp), .extAddrSupported(extAddrSupported), .extIndHigh(extIndHigh),
   .pushReq(pushReq), .popAddr(popAddr), .statusFlags(statusFlags)
);

// file: dv/tb_branch_skip_fracmul_exec.sv
// bench: directed and random runs of the slice against a reference model
// assumes the memory model serves the word at the counter and the next one
`timescale 1ns/100ps
module tb_branch_skip_fracmul_exec;
   logic clk, sysRst, instrValid, instrReady, retire, unknownOp, extAddrSupported, ldEn;
   logic tk, compare_immediate, compare_with_carry;
   logic [15:0] instrWord, followWord, w, z;
   logic [21:0] fetchPc, popAddr, pc, nx;
   logic [5:0] extIndHigh;
   logic [4:0] peekAddr;
   logic [7:0] peekData, ldAddr, fl;
   logic [31:0] ldData, seed;
   logic [15:0] fwt [3] = '{16'h940E, 16'h9200, 16'h2C00};
   exec_pkg::stack_s pushReq;
   exec_pkg::status_s statusFlags;
   int rf [32];
   int n_fail = 0;
   int n_checks = 0;
   int d, r, s;
   // ----------------------------------------
   // design and memory model
   // ----------------------------------------
   branch_skip_fracmul_exec branch_skip_fracmul_exec_inst (
      .clk(clk), .sys_rst(sysRst), .instrValid(instrValid), .instrWord(instrWord),
      .followWord(followWord), .instrReady(instrReady), .fetchPc(fetchPc), .retire(retire),
      .unknownOp(unknownOp), .extAddrSupported(extAddrSupported), .extIndHigh(extIndHigh),
      .pushReq(pushReq), .popAddr(popAddr), .statusFlags(statusFlags), .peekAddr(peekAddr),
      .peekData(peekData)
   );
   prog_mem_model prog_mem_model_inst (
      .clk(clk), .ldEn(ldEn), .ldAddr(ldAddr), .ldData(ldData), .fetchPc(fetchPc),
      .instrWord(instrWord), .followWord(followWord)
   );
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   function automatic logic [15:0] enc(input logic [15:0] b, input int e, input int f);
      return b | 16'((f & 16) << 5 | e << 4 | (f & 15));
   endfunction : enc
   function automatic logic [15:0] imm(input logic [15:0] b, input int e, input int k);
      return b | 16'((k & 240) << 4 | (e - 16) << 4 | (k & 15));
   endfunction : imm
   // compare flags: difference discarded, six flags updated
   function automatic logic [7:0] cmpf(input int a, input int b, input int ci, input logic ch);
      int q;
      logic [7:0] o;
      q = (a - b - ci) & 255;
      o = fl;
      o[0] = a < b + ci;
      o[5] = (a & 15) < (b & 15) + ci;
      o[3] = ((a ^ b) & (a ^ q) & 128) != 0;
      o[2] = q > 127;
      o[4] = o[2] ^ o[3];
      o[1] = q == 0 && (!ch || fl[1]);
      return o;
   endfunction : cmpf
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
      n_checks++;
      if (v !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, v);
         n_fail++;
      end
   endtask : chk
   // load a word pair, issue once, count cycles to retire
   task automatic step(input logic [15:0] iw, input logic [15:0] fw, input int n,
                       input logic [21:0] np);
      int c;
      @(negedge clk);
      ldEn = 1'b1;
      ldAddr = pc[7:0];
      ldData = {iw, fw};
      @(negedge clk);
      ldEn = 1'b0;
      instrValid = 1'b1;
      @(negedge clk);
      instrValid = 1'b0;
      c = 1;
      while (retire !== 1'b1 && c < 9) begin
         @(negedge clk);
         c++;
      end
      chk("cycles", n, c);
      chk("pc", np, fetchPc);
      chk("flags", fl, statusFlags);
      pc = np;
   endtask : step
   task automatic pk(input int a);
      @(negedge clk);
      peekAddr = a[4:0];
      @(negedge clk);
      chk("reg", rf[a], peekData);
   endtask : pk
   // skip of one or two words, or none
   task automatic skp(input logic [15:0] iw, input logic [15:0] fw, input logic c);
      int m;
      m = ((fw & exec_pkg::M_ABS_ANY) == exec_pkg::V_ABS_JUMP
           || (fw & exec_pkg::M_DIRECT) == exec_pkg::V_DIRECT) ? 3 : 2;
      if (!c) m = 1;
      step(iw, fw, m, pc + 22'(m));
   endtask : skp
   task automatic fm(input logic u);
      int a, b, p;
      a = rf[d] > 127 ? rf[d] - 256 : rf[d];
      b = (rf[r] > 127 && !u) ? rf[r] - 256 : rf[r];
      p = a * b;
      fl[0] = p[15];
      p = (p << 1) & 65535;
      fl[1] = p == 0;
      step(exec_pkg::V_FMUL | {12'h000, u, 3'h0} | 16'((d - 16) << 4 | (r - 16)), 0, 2, pc + 1);
      rf[0] = p & 255;
      rf[1] = p >> 8;
      pk(0);
      pk(1);
   endtask : fm
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_of_test
   // ----------------------------------------
   // clock, watchdog and main sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (6000) @(posedge clk);
      n_fail++;
      end_of_test();
   end
   initial begin
      {sysRst, instrValid, ldEn, extAddrSupported} = 4'h9;
      {ldAddr, ldData, popAddr, extIndHigh, peekAddr, fl, pc} = '0;
      seed = 32'h000117BC;
      foreach (rf[i]) rf[i] = 0;
      repeat (5) @(negedge clk);
      sysRst = 1'b0;
      chk("pc", 0, fetchPc);
      chk("flags", 0, statusFlags);
      pk(0);
      for (int i = 16; i < 32; i++) begin
         seed = xs(seed);
         step(imm(exec_pkg::V_LDI, i, seed[7:0]), 0, 1, pc + 1);
         rf[i] = seed[7:0];
         pk(i);
      end
      // compare then branch, every flag and both senses
      for (int i = 0; i < 32; i++) begin
         seed = xs(seed);
         d = 16 + seed[2:0];
         r = 16 + seed[5:3];
         s = seed[31:24];
         if (i == 16) begin
            popAddr = seed[21:0];
            step(exec_pkg::V_SUB_EXIT, 0, 4, popAddr);
            popAddr = ~popAddr;
            fl[7] = 1'b1;
            step(exec_pkg::V_INT_EXIT, 0, 4, popAddr);
         end
         compare_immediate = seed[6];
         compare_with_carry = seed[7] && !compare_immediate;
         fl = cmpf(rf[d], compare_immediate ? s : rf[r], compare_with_carry ? fl[0] : 0, compare_with_carry);
         w = compare_immediate ? imm(exec_pkg::V_CPI, d, s) : enc(compare_with_carry ? exec_pkg::V_CPC : exec_pkg::V_CP, d, r);
         step(w, 0, 1, pc + 1);
         w = (i[3] ? exec_pkg::V_BR_ZERO : exec_pkg::V_BR_ONE) | {6'h00, seed[15:9], i[2:0]};
         tk = fl[i[2:0]] ^ i[3];
         nx = pc + 22'h000001 + (tk ? {{15{seed[15]}}, seed[15:9]} : 22'h000000);
         step(w, 0, tk ? 2 : 1, nx);
      end
      repeat (8) begin
         seed = xs(seed);
         d = 16 + seed[2:0];
         r = 16 + seed[5:3];
         fm(seed[6]);
      end
      // bit skips and compare-skip over short and long words
      for (int i = 0; i < 16; i++) begin
         seed = xs(seed);
         d = 16 + seed[3:0];
         w = i[3] ? exec_pkg::V_SKIP_SET : exec_pkg::V_SKIP_CLR;
         skp(enc(w, d, i[2:0]), fwt[i % 3], rf[d][i[2:0]] ^ !i[3]);
         r = i[0] ? d : 16 + seed[7:4];
         skp(enc(exec_pkg::V_COMPARE_SKIP_EQUAL, d, r), fwt[(i + 1) % 3], rf[d] == rf[r]);
      end
      step(enc(exec_pkg::V_MOV, 2, 16), 0, 1, pc + 1);
      rf[2] = rf[16];
      step(exec_pkg::V_REGISTER_PAIR_COPY | 16'h002F, 0, 1, pc + 1);
      rf[4] = rf[30];
      rf[5] = rf[31];
      pk(2);
      pk(4);
      pk(5);
      z = {rf[31][7:0], rf[30][7:0]};
      step(exec_pkg::V_IND_JUMP, 0, 2, {6'h00, z});
      step(exec_pkg::V_IND_CALL, 0, 2, {6'h00, z});
      extIndHigh = seed[5:0];
      step(exec_pkg::V_EXT_IND_JUMP, 0, 2, {extIndHigh, z});
      step(exec_pkg::V_EXT_IND_CALL, 0, 2, {extIndHigh, z});
      extAddrSupported = 1'b0;
      step(exec_pkg::V_EXT_IND_JUMP, 0, 1, pc + 1);
      step(exec_pkg::V_EXT_IND_CALL, 0, 1, pc + 1);
      seed = xs(seed);
      w = {7'h00, seed[21:17], 3'h0, seed[16]};
      step(exec_pkg::V_ABS_JUMP | w, seed[15:0], 3, seed[21:0]);
      seed = xs(seed);
      w = {7'h00, seed[21:17], 3'h0, seed[16]};
      step(exec_pkg::V_ABS_CALL | w, seed[15:0], 3, seed[21:0]);
      end_of_test();
   end
endmodule : tb_branch_skip_fracmul_exec
